// >>> hw/afe_regs_defs.svh
// register map, field positions, slave pattern and reset values of the serial slave
// assumes: included by bare name wherever a number of the register space is needed
`ifndef AFE_REGS_DEFS_SVH
`define AFE_REGS_DEFS_SVH

// ***************************************
// register space
// ***************************************
`define REG_COUNT        11
`define REG_LAST         4'hA
`define REG_FIRST        4'h0
`define REG_BALANCE      4'h3
`define REG_SWITCH       4'h4
`define REG_FLAGS        4'h9

// ***************************************
// fields
// ***************************************
`define CELLS            6
`define BIT_CHARGE       0
`define BIT_DISCHARGE    1
`define BIT_FORCE_POR    7
`define FLAG_LSB         0
`define FLAG_MSB         3

// ***************************************
// slave pattern and reset values
// ***************************************
`define SLAVE_BASE       6'h14
`define RESET_BYTE       8'h00
`define RESET_PTR        4'h0
`define PINS_IDLE        4'h3

`endif

// >>> hw/afe_types_pkg.sv
// types of the serial slave's bus engine: its states and byte kinds
// assumes: compiled before every file that names afe_types_pkg
`default_nettype none

package afe_types_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RX,
      ST_ACK,
      ST_TX,
      ST_TXACK,
      ST_IGNORE
   } state_t;

   typedef enum logic [1:0] {
      K_SLAVE,
      K_ADDR,
      K_DATA
   } kind_t;

endpackage : afe_types_pkg

`default_nettype wire

// >>> hw/reg_if.sv
// carrier between the serial engine and the register file
// assumes: both ends sit on the same clock
`timescale 1ns/1ns
`default_nettype none

interface reg_if;
   logic       wr;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       por;
   logic [7:0] bal_q;
   logic [7:0] sw_q;
   logic [7:0] flag_q;

   modport engine (output wr, output addr, output wdata,
                   input rdata, input por, input bal_q, input sw_q, input flag_q);
   modport regs   (input wr, input addr, input wdata,
                   output rdata, output por, output bal_q, output sw_q, output flag_q);
endinterface : reg_if

`default_nettype wire

// >>> hw/pin_sync.sv
// two-flip-flop synchroniser for a group of pin levels
// assumes: inputs are asynchronous to clk; reset takes the idle levels
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
   parameter int              W  = 1,
   parameter logic [W-1:0]    RV = '0
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // levels
   input  wire logic [W-1:0]  d,
   output logic      [W-1:0]  q
);

   logic [W-1:0] meta_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= RV;
         q      <= RV;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule : pin_sync

`default_nettype wire

// >>> hw/afe_reg_file.sv
// register space 0 to 0AH with balance, switch, flag and forced reset fields
// assumes: one write strobe per byte from the serial engine, same clock
`timescale 1ns/1ns
`default_nettype none
`include "afe_regs_defs.svh"

module afe_reg_file (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // over-temperature shutdown, synchronised
   input  wire logic ot_active,
   // engine side
   reg_if.regs       bus
);

   logic [7:0] mem_r [`REG_COUNT];
   logic       por_r;

   wire in_range   = (bus.addr <= `REG_LAST);
   wire hit_bal    = (bus.addr == `REG_BALANCE);
   wire hit_sw     = (bus.addr == `REG_SWITCH);
   wire force_por  = bus.wr && hit_sw && bus.wdata[`BIT_FORCE_POR];
   wire wr_ok      = bus.wr && in_range && !force_por && !(ot_active && hit_bal);
   // switch bits hold their value while shutdown is active
   wire [7:0] sw_keep = {6'h00, mem_r[`REG_SWITCH][`BIT_DISCHARGE:`BIT_CHARGE]};
   wire [7:0] sw_mask = 8'h03;
   wire [7:0] wval    = (ot_active && hit_sw) ?
                        ((bus.wdata & ~sw_mask) | sw_keep) : bus.wdata;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < `REG_COUNT; i++) mem_r[i] <= `RESET_BYTE;
         por_r <= 1'b0;
      end else if (force_por) begin
         // forced power-on reset wipes the user flags too
         for (int i = 0; i < `REG_COUNT; i++) mem_r[i] <= `RESET_BYTE;
         por_r <= 1'b1;
      end else begin
         por_r <= 1'b0;
         // flags are never touched by sleep, only by writes and resets
         if (wr_ok) mem_r[bus.addr] <= wval;
      end
   end

   assign bus.rdata  = in_range ? mem_r[bus.addr] : `RESET_BYTE;
   assign bus.por    = por_r;
   assign bus.bal_q  = mem_r[`REG_BALANCE];
   assign bus.sw_q   = mem_r[`REG_SWITCH];
   assign bus.flag_q = mem_r[`REG_FLAGS];

endmodule : afe_reg_file

`default_nettype wire

// >>> hw/battery_afe_serial_slave_regs.sv
// two-wire serial slave of the pack monitor: bus engine, pointer and control outputs
// assumes: SCL and SDA come from pins and are sampled on CLK, which must run far faster
//          than SCL; SDA is open drain and the pad resolves SDA_OE into the wire level
//
// Function
// - one balance bit per cell; set turns its balance switch on, clear off
// - four user flag bits held in a register the host writes
// - user flags keep their contents through sleep
// - writing the forced reset bit resets the device and clears user flags
// - slave only; never starts a transfer and never drives the clock
// - every byte travels most significant bit first
// - data changes only while clock low; changes with clock high are start/stop
// - watch for start always; ignore the bus until one arrives
// - stop ends any transfer; after a read it enters standby
// - transmitter releases data after eight bits; receiver pulls low on ninth clock
// - acknowledge matching slave byte and every later write byte but a forced reset one; mismatch stays silent
// - read: send eight bits, release, sample ack; continue only while acknowledged
// - received data byte loads on the clock fall after its eighth bit
// - pointer advances after each written byte's ack; wraps from 0AH to 0
// - after a read slave byte ack, one data bit per master clock
// - pointer advances after the eighth bit of each read byte
// - current-address read starts at the internal pointer
// - lower device matches 0101000, upper 0101001; lowest bit gives direction
// - during over-temperature shutdown ignore balance and switch bit writes
`timescale 1ns/1ns
`default_nettype none
`include "afe_regs_defs.svh"

module battery_afe_serial_slave_regs (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_N,
   // serial bus, SDA is open drain
   input  wire logic        SCL,
   input  wire logic        SDA_IN,
   output logic             SDA_OUT,
   output logic             SDA_OE,
   // strap and analog status
   input  wire logic        CASCADE_UPPER,
   input  wire logic        OT_SHUTDOWN,
   // cell balance and pack switches
   output logic [5:0]       CELL_BALANCE,
   output logic             CHARGE_SWITCH_CONTROL,
   output logic             DISCHARGE_SWITCH_CONTROL,
   // user flags
   output logic             USER_FLAG_0,
   output logic             USER_FLAG_1,
   output logic             USER_FLAG_2,
   output logic             USER_FLAG_3,
   // engine status
   output logic             STANDBY,
   output logic             BUSY
);

   // ***************************************
   // reset release
   // ***************************************
   logic rst_meta_r;
   logic rst_n;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   // ***************************************
   // pin sampling
   // ***************************************
   logic [3:0] pins_s;
   logic       scl_d_r;
   logic       sda_d_r;

   pin_sync #(
      .W  (4),
      .RV (`PINS_IDLE)
   ) u_pin_sync (
      .clk   (CLK),
      .rst_n (rst_n),
      .d     ({OT_SHUTDOWN, CASCADE_UPPER, SDA_IN, SCL}),
      .q     (pins_s)
   );

   wire scl_s   = pins_s[0];
   wire sda_s   = pins_s[1];
   wire upper_s = pins_s[2];
   wire ot_s    = pins_s[3];

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   // ***************************************
   // bus conditions
   // ***************************************
   // SCL is only ever read, never driven
   wire scl_rise = scl_s && !scl_d_r;
   wire scl_fall = !scl_s && scl_d_r;
   // data moving under a high clock is a condition, not a bit
   wire start_c  = scl_s && scl_d_r && sda_d_r && !sda_s;
   wire stop_c   = scl_s && scl_d_r && !sda_d_r && sda_s;

   // ***************************************
   // register file
   // ***************************************
   reg_if rif ();

   afe_reg_file u_regs (
      .clk       (CLK),
      .rst_n     (rst_n),
      .ot_active (ot_s),
      .bus       (rif.regs)
   );

   // ***************************************
   // engine state
   // ***************************************
   afe_types_pkg::state_t state_r;
   afe_types_pkg::state_t state_nxt;
   afe_types_pkg::kind_t  kind_r;
   afe_types_pkg::kind_t  kind_nxt;
   logic [3:0]            cnt_r;
   logic [3:0]            cnt_nxt;
   logic [7:0]            sh_r;
   logic [7:0]            sh_nxt;
   logic [3:0]            ptr_r;
   logic [3:0]            ptr_nxt;
   logic                  oe_r;
   logic                  oe_nxt;
   logic                  rd_r;
   logic                  rd_nxt;
   logic                  ack_r;
   logic                  ack_nxt;
   logic                  standby_r;
   logic                  standby_nxt;
   logic                  wr_nxt;

   // ***************************************
   // decode
   // ***************************************
   wire [6:0] own_pattern = {`SLAVE_BASE, upper_s};
   wire       slave_hit   = (sh_r[7:1] == own_pattern);
   wire       byte_done   = (cnt_r == 4'h8);
   wire [3:0] ptr_inc     = (ptr_r == `REG_LAST) ? `REG_FIRST : (ptr_r + 4'h1);
   // an address beyond the map restarts at the first register
   wire [3:0] ptr_load    = (sh_r <= {4'h0, `REG_LAST}) ? sh_r[3:0] : `REG_FIRST;
   wire [7:0] rd_byte     = rif.rdata;

   // ***************************************
   // next state
   // ***************************************
   always_comb begin
      state_nxt   = state_r;
      kind_nxt    = kind_r;
      cnt_nxt     = cnt_r;
      sh_nxt      = sh_r;
      ptr_nxt     = ptr_r;
      oe_nxt      = oe_r;
      rd_nxt      = rd_r;
      ack_nxt     = ack_r;
      standby_nxt = standby_r;
      wr_nxt      = 1'b0;

      if (rif.por) begin
         // forced reset: pointer home and the line let go
         state_nxt = afe_types_pkg::ST_IDLE;
         ptr_nxt   = `RESET_PTR;
         oe_nxt    = 1'b0;
         rd_nxt    = 1'b0;
      end else if (start_c) begin
         // a start, repeated or not, always reopens the slave byte
         state_nxt   = afe_types_pkg::ST_RX;
         kind_nxt    = afe_types_pkg::K_SLAVE;
         cnt_nxt     = 4'h0;
         oe_nxt      = 1'b0;
         standby_nxt = 1'b0;
      end else if (stop_c) begin
         state_nxt   = afe_types_pkg::ST_IDLE;
         oe_nxt      = 1'b0;
         standby_nxt = standby_r | rd_r;
         rd_nxt      = 1'b0;
      end else begin
         case (state_r)
            afe_types_pkg::ST_IDLE: begin
               // nothing on the bus matters before a start
               oe_nxt = 1'b0;
            end

            afe_types_pkg::ST_RX: begin
               if (scl_rise && !byte_done) begin
                  sh_nxt  = {sh_r[6:0], sda_s};
                  cnt_nxt = cnt_r + 4'h1;
               end else if (scl_fall && byte_done) begin
                  case (kind_r)
                     afe_types_pkg::K_SLAVE: begin
                        if (slave_hit) begin
                           oe_nxt    = 1'b1;
                           state_nxt = afe_types_pkg::ST_ACK;
                           rd_nxt    = sh_r[0];
                        end else begin
                           // other device's byte: stay silent until the next start or stop
                           state_nxt = afe_types_pkg::ST_IGNORE;
                        end
                     end
                     afe_types_pkg::K_ADDR: begin
                        ptr_nxt   = ptr_load;
                        oe_nxt    = 1'b1;
                        state_nxt = afe_types_pkg::ST_ACK;
                     end
                     default: begin
                        // byte lands on this very fall
                        wr_nxt    = 1'b1;
                        oe_nxt    = 1'b1;
                        state_nxt = afe_types_pkg::ST_ACK;
                     end
                  endcase
               end
            end

            afe_types_pkg::ST_ACK: begin
               if (scl_fall) begin
                  cnt_nxt = 4'h0;
                  if (kind_r == afe_types_pkg::K_SLAVE && rd_r) begin
                     // first read bit goes out as the ack clock falls
                     sh_nxt    = rd_byte;
                     oe_nxt    = !rd_byte[7];
                     cnt_nxt   = 4'h1;
                     state_nxt = afe_types_pkg::ST_TX;
                  end else begin
                     oe_nxt    = 1'b0;
                     state_nxt = afe_types_pkg::ST_RX;
                     case (kind_r)
                        afe_types_pkg::K_SLAVE: kind_nxt = afe_types_pkg::K_ADDR;
                        afe_types_pkg::K_ADDR:  kind_nxt = afe_types_pkg::K_DATA;
                        default: begin
                           kind_nxt = afe_types_pkg::K_DATA;
                           ptr_nxt  = ptr_inc;
                        end
                     endcase
                  end
               end
            end

            afe_types_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (byte_done) begin
                     // release for the master's answer
                     oe_nxt    = 1'b0;
                     ptr_nxt   = ptr_inc;
                     ack_nxt   = 1'b0;
                     state_nxt = afe_types_pkg::ST_TXACK;
                  end else begin
                     sh_nxt  = {sh_r[6:0], 1'b0};
                     oe_nxt  = !sh_r[6];
                     cnt_nxt = cnt_r + 4'h1;
                  end
               end
            end

            afe_types_pkg::ST_TXACK: begin
               if (scl_rise) begin
                  ack_nxt = !sda_s;
               end else if (scl_fall) begin
                  if (ack_r) begin
                     sh_nxt    = rd_byte;
                     oe_nxt    = !rd_byte[7];
                     cnt_nxt   = 4'h1;
                     state_nxt = afe_types_pkg::ST_TX;
                  end else begin
                     // no ack: hold off the bus and wait for the next start or stop
                     oe_nxt    = 1'b0;
                     state_nxt = afe_types_pkg::ST_IGNORE;
                  end
               end
            end

            afe_types_pkg::ST_IGNORE: begin
               oe_nxt = 1'b0;
            end

            default: begin
               state_nxt = afe_types_pkg::ST_IDLE;
               oe_nxt    = 1'b0;
            end
         endcase
      end
   end

   // ***************************************
   // engine registers
   // ***************************************
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         state_r   <= afe_types_pkg::ST_IDLE;
         kind_r    <= afe_types_pkg::K_SLAVE;
         cnt_r     <= 4'h0;
         sh_r      <= `RESET_BYTE;
         ptr_r     <= `RESET_PTR;
         oe_r      <= 1'b0;
         rd_r      <= 1'b0;
         ack_r     <= 1'b0;
         standby_r <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         kind_r    <= kind_nxt;
         cnt_r     <= cnt_nxt;
         sh_r      <= sh_nxt;
         ptr_r     <= ptr_nxt;
         oe_r      <= oe_nxt;
         rd_r      <= rd_nxt;
         ack_r     <= ack_nxt;
         standby_r <= standby_nxt;
      end
   end

   // ***************************************
   // register access
   // ***************************************
   // the write strobe is one cycle, taken on the same edge as the fall is seen
   assign rif.wr    = wr_nxt;
   assign rif.addr  = ptr_r;
   assign rif.wdata = sh_r;

   // ***************************************
   // control outputs
   // ***************************************
   // shutdown holds balance and switches off whatever is stored
   logic [5:0] bal_r;
   logic       chg_r;
   logic       dis_r;
   logic [3:0] flag_r;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         bal_r  <= 6'h00;
         chg_r  <= 1'b0;
         dis_r  <= 1'b0;
         flag_r <= 4'h0;
      end else begin
         bal_r  <= rif.bal_q[`CELLS-1:0] & {`CELLS{!ot_s}};
         chg_r  <= rif.sw_q[`BIT_CHARGE] & !ot_s;
         dis_r  <= rif.sw_q[`BIT_DISCHARGE] & !ot_s;
         flag_r <= rif.flag_q[`FLAG_MSB:`FLAG_LSB];
      end
   end

   assign CELL_BALANCE             = bal_r;
   assign CHARGE_SWITCH_CONTROL    = chg_r;
   assign DISCHARGE_SWITCH_CONTROL = dis_r;
   assign USER_FLAG_0              = flag_r[0];
   assign USER_FLAG_1              = flag_r[1];
   assign USER_FLAG_2              = flag_r[2];
   assign USER_FLAG_3              = flag_r[3];

   // ***************************************
   // pins and status
   // ***************************************
   // open drain: only ever pull low
   assign SDA_OUT = 1'b0;
   assign SDA_OE  = oe_r;
   assign STANDBY = standby_r;
   assign BUSY    = (state_r != afe_types_pkg::ST_IDLE);

endmodule : battery_afe_serial_slave_regs

`default_nettype wire

// >>> sim/afe_chk.sv
// pin-level assertions for the serial slave
// assumes: bound to the top module; one clock domain
`timescale 1ns/1ns
`default_nettype none

module afe_chk (
   // clock and reset
   input wire logic       CLK,
   input wire logic       RST_N,
   // serial bus
   input wire logic       SCL,
   input wire logic       SDA_IN,
   input wire logic       SDA_OUT,
   input wire logic       SDA_OE,
   // control and status
   input wire logic       OT_SHUTDOWN,
   input wire logic [5:0] CELL_BALANCE,
   input wire logic       CHARGE_SWITCH_CONTROL,
   input wire logic       DISCHARGE_SWITCH_CONTROL,
   input wire logic       STANDBY,
   input wire logic       BUSY
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);

   // ****
   // bus conditions on the pins
   // ****
   sequence start_s;
      SCL && $past(SCL) && $fell(SDA_IN);
   endsequence
   sequence stop_s;
      SCL && $past(SCL) && $rose(SDA_IN);
   endsequence

   chk_drain_zero: assert property (SDA_OUT == 1'h0 && (!SDA_OE || !SDA_IN))
      else $error("sda output value not low");
   chk_oe_scl_low: assert property ($changed(SDA_OE) |-> !SCL && !$past(SCL, 2))
      else $error("sda drive changed with clock high");
   chk_start_busy: assert property (start_s |-> ##[1:5] BUSY)
      else $error("start not taken");
   chk_stop_idle: assert property (stop_s |-> ##[1:5] !BUSY)
      else $error("stop did not end transfer");
   chk_start_wake: assert property (STANDBY ##0 start_s |-> ##[1:5] !STANDBY)
      else $error("standby kept after start");
   chk_standby_idle: assert property ($rose(STANDBY) |-> ##[0:2] !BUSY)
      else $error("standby while busy");
   chk_idle_release: assert property (!BUSY [*2] |-> !SDA_OE)
      else $error("sda driven while idle");
   chk_ot_gate: assert property (OT_SHUTDOWN [*5] |-> CELL_BALANCE == 6'h00
      && !CHARGE_SWITCH_CONTROL && !DISCHARGE_SWITCH_CONTROL)
      else $error("switch on during shutdown");

   cover property ($rose(STANDBY));
   cover property ($rose(SDA_OE));
   cover property (OT_SHUTDOWN && $fell(BUSY));
endmodule : afe_chk

`default_nettype wire

// >>> sim/afe_host.sv
// two-wire bus master standing in for the host controller
// assumes: sda is the resolved wire with its pull-up
`timescale 1ns/1ns
`default_nettype none

module afe_host (
   // bench clock
   input  wire logic clk,
   // bus
   input  wire logic sda,
   output logic      scl = 1'h1,
   output logic      pull_low = 1'h0
);
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   // ****
   // bit slot: data moves only with clock low
   // ****
   task automatic slot(input logic b, output logic s);
      pull_low <= !b;
      tick(8);
      scl <= 1'h1;
      tick(4);
      s = sda;
      tick(4);
      scl <= 1'h0;
      tick(1);
   endtask : slot

   // gap lets the slave release its ack first
   task automatic start();
      pull_low <= 1'h0;
      tick(4);
      scl <= 1'h1;
      tick(8);
      pull_low <= 1'h1;
      tick(8);
      scl <= 1'h0;
      tick(1);
   endtask : start

   task automatic stop();
      pull_low <= 1'h1;
      tick(8);
      scl <= 1'h1;
      tick(8);
      pull_low <= 1'h0;
      tick(8);
   endtask : stop

   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         slot(d[i], s);
      slot(1'h1, s);
      ack = !s;
   endtask : wbyte

   task automatic rbyte(input logic more, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
         slot(1'h1, d[i]);
      slot(!more, s);
   endtask : rbyte
endmodule : afe_host

`default_nettype wire

// >>> sim/battery_afe_serial_slave_regs_tb.sv
// self-checking bench: host model drives the bus, tasks speak register transfers
// assumes: design, checker and host model compiled first
`timescale 1ns/1ns
`default_nettype none

module battery_afe_serial_slave_regs_tb;
   logic       clk = 1'h0;
   logic       rst_n = 1'h0;
   logic       upper = 1'h0;
   logic       hot = 1'h0;
   logic [7:0] slv = 8'h50;
   logic       k;
   int         failures = 0;
   int         total_checks = 0;
   wire        sda_oe;
   wire        pull;
   wire        scl;
   wire        sda;
   wire        chg;
   wire        dchg;
   wire        standby;
   wire [5:0]  bal;
   wire [3:0]  flags;

   always #5 clk = ~clk;
   assign sda = !(pull || sda_oe);

   battery_afe_serial_slave_regs i_battery_afe_serial_slave_regs (.CLK(clk), .RST_N(rst_n),
      .SCL(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe), .CASCADE_UPPER(upper),
      .OT_SHUTDOWN(hot), .CELL_BALANCE(bal), .CHARGE_SWITCH_CONTROL(chg),
      .DISCHARGE_SWITCH_CONTROL(dchg), .USER_FLAG_0(flags[0]), .USER_FLAG_1(flags[1]),
      .USER_FLAG_2(flags[2]), .USER_FLAG_3(flags[3]), .STANDBY(standby), .BUSY());
   afe_host i_afe_host (.clk(clk), .sda(sda), .scl(scl), .pull_low(pull));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report

   task automatic wr(input logic [3:0] a, input int n, input logic [7:0] d [3]);
      i_afe_host.start();
      i_afe_host.wbyte(slv, k);
      check(k, 1'h1);
      i_afe_host.wbyte({4'h0, a}, k);
      check(k, 1'h1);
      for (int i = 0; i < n; i++) begin
         i_afe_host.wbyte(d[i], k);
         check(k, 1'h1);
      end
      i_afe_host.stop();
   endtask : wr

   // cur set: current-address read, no address phase
   task automatic rd(input logic cur, input logic [3:0] a, input int n, input logic [7:0] e [3]);
      logic [7:0] d;
      if (!cur) begin
         i_afe_host.start();
         i_afe_host.wbyte(slv, k);
         i_afe_host.wbyte({4'h0, a}, k);
      end
      i_afe_host.start();
      i_afe_host.wbyte(slv | 8'h01, k);
      check(k, 1'h1);
      for (int i = 0; i < n; i++) begin
         i_afe_host.rbyte(i < n - 1, d);
         check(d, e[i]);
      end
      i_afe_host.stop();
   endtask : rd

   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'h1;
      repeat (6) @(posedge clk);
      check(sda_oe, 1'h0);
      wr(4'h3, 1, '{8'h2A, 8'h00, 8'h00});
      check(bal, 6'h2A);
      wr(4'h4, 1, '{8'h03, 8'h00, 8'h00});
      check({dchg, chg}, 2'h3);
      wr(4'h9, 1, '{8'h05, 8'h00, 8'h00});
      check(flags, 4'h5);
      wr(4'hA, 3, '{8'h11, 8'h22, 8'h33});
      rd(1'h0, 4'hA, 2, '{8'h11, 8'h22, 8'h00});
      check(standby, 1'h1);
      rd(1'h1, 4'h0, 1, '{8'h33, 8'h00, 8'h00});
      i_afe_host.start();
      i_afe_host.wbyte(8'h52, k);
      check(k, 1'h0);
      i_afe_host.stop();
      upper <= 1'h1;
      slv = 8'h52;
      wr(4'h9, 1, '{8'h0A, 8'h00, 8'h00});
      check(flags, 4'hA);
      hot <= 1'h1;
      wr(4'h3, 2, '{8'h3F, 8'h00, 8'h00});
      hot <= 1'h0;
      repeat (5) @(posedge clk);
      check(bal, 6'h2A);
      check({dchg, chg}, 2'h3);
      // forced reset drops the engine to idle, so its own ack is withdrawn
      i_afe_host.start();
      i_afe_host.wbyte(slv, k);
      check(k, 1'h1);
      i_afe_host.wbyte(8'h04, k);
      check(k, 1'h1);
      i_afe_host.wbyte(8'h80, k);
      check(k, 1'h0);
      i_afe_host.stop();
      check(flags, 4'h0);
      check({bal, dchg, chg}, 8'h00);
      rd(1'h1, 4'h0, 1, '{8'h00, 8'h00, 8'h00});
      final_report();
   end

   // 34 bytes at some 150 cycles each; a wide margin on top
   initial begin
      #300000;
      failures++;
      final_report();
   end
endmodule : battery_afe_serial_slave_regs_tb

bind battery_afe_serial_slave_regs afe_chk i_afe_chk (.CLK(CLK), .RST_N(RST_N), .SCL(SCL),
   .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .OT_SHUTDOWN(OT_SHUTDOWN),
   .CELL_BALANCE(CELL_BALANCE), .CHARGE_SWITCH_CONTROL(CHARGE_SWITCH_CONTROL),
   .DISCHARGE_SWITCH_CONTROL(DISCHARGE_SWITCH_CONTROL), .STANDBY(STANDBY), .BUSY(BUSY));

`default_nettype wire
